// ---- bench/ceils_far_side.sv ----
`timescale 1ns/10ps
module ceils_far_side (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Device side
  input  wire logic mc_oe,
  input  wire logic shutdown_req,
  input  wire logic lock_out,
  // Other agents
  input  wire logic other_mc,
  input  wire logic prio_req,
  output logic      mc_line,
  output logic      nmi_seen,
  output logic      prio_grant
);
  // Pulled-up wired line, low while any agent drives it
  assign mc_line = !(mc_oe || other_mc);
  // Chipset turns a shutdown into a sticky NMI
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) nmi_seen <= 1'h0;
    else if (shutdown_req) nmi_seen <= 1'h1;
  end
  // Priority agent takes the bus only once lock is gone
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) prio_grant <= 1'h0;
    else prio_grant <= prio_req && !lock_out;
  end
endmodule

// ---- bench/tb_ceils_sideband.sv ----
`timescale 1ns/10ps
module tb_ceils_sideband;
  import ceils_pkg::*;
  logic       mclk = 1'h0;
  logic       sys_rst = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] ev = 8'h00;
  logic       ignore_numeric_fault_in = 1'h0, soft_init_n_in = 1'h1;
  logic [1:0] local_irq_in = 2'h0;
  logic       other_mc = 1'h0, prio_req = 1'h0;
  logic [7:0] reg_rdata;
  logic [1:0] lic_lines;
  logic       irq, machine_check_fault_in, internal_fault_out, shutdown_req, lock_out;
  logic       lock_oe, machine_check_fault_out, machine_check_fault_oe, fp_exception;
  logic       fp_pending, int_regs_clear, resume_at_reset_vector, snoop_ack;
  logic       maskable_irq_request, nmi_request, nmi_seen, prio_grant;
  int         n_errors = 0, checks = 0;

  always #4 mclk = ~mclk;

  ceils_sideband dut_u (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .core_internal_fault(ev[0]), .fp_op_issue(ev[1]),
    .fp_op_error(ev[2]), .lock_seq_start(ev[3]), .lock_seq_end(ev[4]),
    .bus_req_error(ev[5]), .bus_obs_error(ev[6]), .snoop_req(ev[7]),
    .ignore_numeric_fault_in, .soft_init_n_in, .local_irq_in, .machine_check_fault_in,
    .internal_fault_out, .shutdown_req, .lock_out, .lock_oe, .machine_check_fault_out,
    .machine_check_fault_oe, .fp_exception, .fp_pending, .int_regs_clear,
    .resume_at_reset_vector, .snoop_ack, .maskable_irq_request, .nmi_request,
    .lic_lines);

  ceils_far_side far_u (.mclk, .sys_rst, .mc_oe(machine_check_fault_oe), .shutdown_req,
    .lock_out, .other_mc, .prio_req, .mc_line(machine_check_fault_in), .nmi_seen,
    .prio_grant);

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task stop_test;
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
    #1;
  endtask

  task rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, e);
  endtask

  task pulse(input int k);
    @(posedge mclk);
    ev[k] <= 1'h1;
    @(posedge mclk);
    ev[k] <= 1'h0;
    #1;
  endtask

  task do_rst;
    @(posedge mclk) sys_rst <= 1'h1;
    tick(2);
    chk({internal_fault_out, shutdown_req, lock_out, machine_check_fault_oe}, 8'h00);
    tick(1);
    @(posedge mclk) sys_rst <= 1'h0;
  endtask

  task mcase(input logic [7:0] cfg, input int k, input logic e);
    wr(ADDR_MCCFG, cfg);
    pulse(k);
    chk({machine_check_fault_out, machine_check_fault_oe, machine_check_fault_in}, {e, !e});
  endtask

  task t_regs;
    rdc(ADDR_CTRL, {6'h00, CTRL_RST});
    rdc(ADDR_MCCFG, {4'h0, MCCFG_RST});
    rdc(ADDR_STATUS, 8'h00);
    wr(ADDR_MASK, 8'h07);
    rdc(ADDR_MASK, 8'h07);
    wr(ADDR_STATE, 8'hFF);
    rdc(ADDR_STATE, 8'h00);
    wr(4'hF, 8'hFF);
    rdc(4'hF, 8'h00);
    wr(ADDR_MASK, {5'h00, MASK_RST});
    $display("test regs done");
  endtask

  task t_lint;
    @(posedge mclk) local_irq_in <= 2'h3;
    tick(1);
    chk(lic_lines, 8'h00);
    tick(2);
    chk({maskable_irq_request, nmi_request, lic_lines}, 8'h03);
    rdc(ADDR_STATE, 8'h06);
    wr(ADDR_CTRL, 8'h00);
    @(posedge mclk) local_irq_in <= 2'h1;
    tick(3);
    chk({maskable_irq_request, nmi_request}, 8'h02);
    @(posedge mclk) local_irq_in <= 2'h2;
    tick(3);
    chk({maskable_irq_request, nmi_request}, 8'h01);
    wr(ADDR_CTRL, {6'h00, CTRL_RST});
    @(posedge mclk) local_irq_in <= 2'h0;
    $display("test lint done");
  endtask

  task t_fp;
    pulse(2);
    chk(fp_pending, 8'h01);
    pulse(1);
    chk(fp_exception, 8'h01);
    @(posedge mclk) ignore_numeric_fault_in <= 1'h1;
    tick(3);
    pulse(2);
    pulse(1);
    chk({fp_exception, fp_pending}, 8'h01);
    rdc(ADDR_STATE, 8'h08);
    wr(ADDR_CTRL, 8'h03);
    pulse(1);
    chk(fp_exception, 8'h01);
    wr(ADDR_CTRL, {6'h00, CTRL_RST});
    @(posedge mclk) ignore_numeric_fault_in <= 1'h0;
    $display("test fp done");
  endtask

  task t_init;
    @(posedge mclk) soft_init_n_in <= 1'h0;
    tick(3);
    chk(int_regs_clear, 8'h01);
    pulse(7);
    chk(snoop_ack, 8'h01);
    rdc(ADDR_STATUS, 8'h02);
    @(posedge mclk) soft_init_n_in <= 1'h1;
    tick(3);
    chk(resume_at_reset_vector, 8'h01);
    tick(1);
    chk({resume_at_reset_vector, int_regs_clear}, 8'h00);
    wr(ADDR_STATUS, 8'h02);
    rdc(ADDR_STATUS, 8'h00);
    $display("test init done");
  endtask

  task t_mc;
    @(posedge mclk) other_mc <= 1'h1;
    tick(4);
    rdc(ADDR_STATUS, 8'h04);
    @(posedge mclk) other_mc <= 1'h0;
    mcase(8'h00, 5, 1'h0);
    mcase(8'h01, 5, 1'h0);
    mcase(8'h05, 6, 1'h0);
    mcase(8'h05, 5, 1'h1);
    $display("test mc done");
  endtask

  task t_lock;
    pulse(3);
    chk({lock_out, lock_oe}, 8'h03);
    rdc(ADDR_STATE, 8'h10);
    @(posedge mclk) prio_req <= 1'h1;
    tick(2);
    chk(prio_grant, 8'h00);
    pulse(4);
    chk(lock_out, 8'h01);
    tick(1);
    chk(lock_out, 8'h00);
    tick(1);
    chk(prio_grant, 8'h01);
    @(posedge mclk) prio_req <= 1'h0;
    pulse(3);
    do_rst;
    $display("test lock done");
  endtask

  task t_fault;
    wr(ADDR_MCCFG, 8'h01);
    pulse(0);
    chk({internal_fault_out, shutdown_req, machine_check_fault_oe}, 8'h06);
    tick(1);
    chk({internal_fault_out, shutdown_req, nmi_seen}, 8'h05);
    rdc(ADDR_STATUS, 8'h01);
    chk(irq, 8'h00);
    wr(ADDR_MASK, 8'h01);
    chk(irq, 8'h01);
    wr(ADDR_STATUS, 8'h01);
    chk(irq, 8'h00);
    wr(ADDR_MCCFG, 8'h03);
    pulse(0);
    chk({internal_fault_out, shutdown_req, machine_check_fault_oe}, 8'h05);
    rdc(ADDR_STATE, 8'h01);
    do_rst;
    mcase(8'h09, 5, 1'h0);
    mcase(8'h09, 6, 1'h1);
    $display("test fault done");
  endtask

  initial begin
    sys_rst <= 1'h1;
    do_rst;
    t_regs;
    t_lint;
    t_fp;
    t_init;
    t_mc;
    t_lock;
    t_fault;
    stop_test;
  end

  initial begin
    #100000;
    n_errors++;
    stop_test;
  end
endmodule

// ---- design/ceils_sideband.sv ----
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/10ps
// Behaviour
// - Internal fault raises internal_fault_out and holds it until system reset.
// - Internal fault also issues one shutdown transaction request on the bus.
// - Ignore input asserted: pending numeric fault ignored, float execution continues.
// - Ignore input deasserted: pending numeric fault raises exception on next float op.
// - Ignore input has no effect while the numeric fault enable bit is set.
// - Soft init resets integer registers only; caches and float registers kept.
// - After soft init execution resumes at the configured reset vector.
// - Snoop requests keep being serviced while soft init is asserted.
// - Controller disabled: local line 0 is maskable, line 1 is nonmaskable.
// - Local interrupt controller is enabled after reset.
// - Both local interrupt inputs are synchronised before use.
// - Lock held from start of first locked transaction to end of last.
// - Any agent may drive machine check line for unrecoverable errors.
// - Machine check: enable, with internal fault, by requester, by any observer.
// - With reset seen, all bus outputs drop within two clocks.
module ceils_sideband
  import ceils_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // Register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  output logic                  irq,
  // Core events
  input  wire logic             core_internal_fault,
  input  wire logic             fp_op_issue,
  input  wire logic             fp_op_error,
  input  wire logic             lock_seq_start,
  input  wire logic             lock_seq_end,
  input  wire logic             bus_req_error,
  input  wire logic             bus_obs_error,
  input  wire logic             snoop_req,
  // Pins
  input  wire logic             ignore_numeric_fault_in,
  input  wire logic             soft_init_n_in,
  input  wire logic [1:0]       local_irq_in,
  input  wire logic             machine_check_fault_in,
  output logic                  internal_fault_out,
  output logic                  shutdown_req,
  output logic                  lock_out,
  output logic                  lock_oe,
  output logic                  machine_check_fault_out,
  output logic                  machine_check_fault_oe,
  // Core side results
  output logic                  fp_exception,
  output logic                  fp_pending,
  output logic                  int_regs_clear,
  output logic                  resume_at_reset_vector,
  output logic                  snoop_ack,
  output logic                  maskable_irq_request,
  output logic                  nmi_request,
  output logic      [1:0]       lic_lines
);

  logic [1:0]      ctrl_reg;
  logic [3:0]      mccfg_reg;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] mask_reg;
  logic [ST_W-1:0] event_next;
  logic [1:0]      ign_sync_reg;
  logic [1:0]      init_sync_reg;
  logic            init_hist_reg;
  logic [1:0]      mcin_sync_reg;
  logic [1:0]      lint_s1_reg;
  logic [1:0]      lint_s2_reg;
  logic            fault_seen_reg;
  ceils_lock_t     lock_reg;
  logic            mc_next;

  // Two-flop synchronisers, one per local interrupt line
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_lint
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          lint_s1_reg[gi] <= 1'b0;
          lint_s2_reg[gi] <= 1'b0;
        end else begin
          lint_s1_reg[gi] <= local_irq_in[gi];
          lint_s2_reg[gi] <= lint_s1_reg[gi];
        end
      end
    end
  endgenerate

  // Other pin synchronisers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ign_sync_reg  <= 2'h0;
      init_sync_reg <= 2'h3;
      mcin_sync_reg <= 2'h3;
    end else begin
      ign_sync_reg  <= {ign_sync_reg[0], ignore_numeric_fault_in};
      init_sync_reg <= {init_sync_reg[0], soft_init_n_in};
      mcin_sync_reg <= {mcin_sync_reg[0], machine_check_fault_in};
    end
  end

  // Control registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg  <= CTRL_RST;
      mccfg_reg <= MCCFG_RST;
      mask_reg  <= MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_CTRL) begin
        ctrl_reg <= reg_wdata[1:0];
      end
      if (reg_addr == ADDR_MCCFG) begin
        mccfg_reg <= reg_wdata[3:0];
      end
      if (reg_addr == ADDR_MASK) begin
        mask_reg <= reg_wdata[ST_W-1:0];
      end
    end
  end

  // Internal fault latch and shutdown pulse
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_seen_reg     <= 1'b0;
      internal_fault_out <= 1'b0;
      shutdown_req       <= 1'b0;
    end else begin
      fault_seen_reg     <= fault_seen_reg | core_internal_fault;
      internal_fault_out <= fault_seen_reg | core_internal_fault;
      shutdown_req       <= core_internal_fault & ~fault_seen_reg;
    end
  end

  // Numeric fault tracking
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fp_pending   <= 1'b0;
      fp_exception <= 1'b0;
    end else begin
      fp_exception <= 1'b0;
      if (fp_op_issue && fp_pending &&
          (ctrl_reg[CTRL_NE_BIT] || !ign_sync_reg[1])) begin
        fp_exception <= 1'b1;
        fp_pending   <= 1'b0;
      end else if (fp_op_error) begin
        fp_pending <= 1'b1;
      end
    end
  end

  // Soft init handling
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      init_hist_reg          <= 1'b1;
      int_regs_clear         <= 1'b0;
      resume_at_reset_vector <= 1'b0;
      snoop_ack              <= 1'b0;
    end else begin
      init_hist_reg          <= init_sync_reg[1];
      int_regs_clear         <= ~init_sync_reg[1];
      resume_at_reset_vector <= ~init_hist_reg & init_sync_reg[1];
      snoop_ack              <= snoop_req;
    end
  end

  // Local interrupt routing
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      maskable_irq_request <= 1'b0;
      nmi_request          <= 1'b0;
      lic_lines            <= 2'h0;
    end else if (ctrl_reg[CTRL_LIC_BIT]) begin
      maskable_irq_request <= 1'b0;
      nmi_request          <= 1'b0;
      lic_lines            <= lint_s2_reg;
    end else begin
      maskable_irq_request <= lint_s2_reg[0];
      nmi_request          <= lint_s2_reg[1];
      lic_lines            <= 2'h0;
    end
  end

  // Atomic lock sequencing
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_reg <= CEILS_LK_IDLE;
    end else begin
      case (lock_reg)
        CEILS_LK_IDLE: begin
          if (lock_seq_start) begin
            lock_reg <= lock_seq_end ? CEILS_LK_WAIT : CEILS_LK_HOLD;
          end
        end
        CEILS_LK_HOLD: begin
          if (lock_seq_end) begin
            lock_reg <= CEILS_LK_WAIT;
          end
        end
        CEILS_LK_WAIT: lock_reg <= CEILS_LK_IDLE;
        default:       lock_reg <= CEILS_LK_IDLE;
      endcase
    end
  end

  always_comb begin
    lock_out = (lock_reg != CEILS_LK_IDLE);
    lock_oe  = lock_out;
  end

  // Machine check drive
  always_comb begin
    mc_next = mccfg_reg[MC_EN_BIT] &&
              ((mccfg_reg[MC_INTERNAL_FAULT_OUT_BIT] && core_internal_fault) ||
               (mccfg_reg[MC_REQ_BIT] && bus_req_error) ||
               (mccfg_reg[MC_OBS_BIT] && bus_obs_error));
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      machine_check_fault_out <= 1'b0;
      machine_check_fault_oe  <= 1'b0;
    end else begin
      machine_check_fault_out <= 1'b0;
      machine_check_fault_oe  <= mc_next;
    end
  end

  // Sticky status, write one to clear, set wins
  always_comb begin
    event_next = '0;
    event_next[ST_INTERNAL_FAULT_OUT_BIT] = core_internal_fault;
    event_next[ST_INIT_BIT] = ~init_sync_reg[1];
    event_next[ST_MC_BIT]   = ~mcin_sync_reg[1] | mc_next;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      status_reg <= '0;
    end else if (reg_wr && reg_addr == ADDR_STATUS) begin
      status_reg <= (status_reg & ~reg_wdata[ST_W-1:0]) | event_next;
    end else begin
      status_reg <= status_reg | event_next;
    end
  end

  always_comb begin
    irq = |(status_reg & mask_reg);
  end

  // Read port
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL:   reg_rdata <= {6'h00, ctrl_reg};
        ADDR_MCCFG:  reg_rdata <= {4'h0, mccfg_reg};
        ADDR_STATUS: reg_rdata <= {5'h00, status_reg};
        ADDR_MASK:   reg_rdata <= {5'h00, mask_reg};
        ADDR_STATE:  reg_rdata <= {3'h0, lock_out, fp_pending, lint_s2_reg,
                                   internal_fault_out};
        default:     reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks
  a_fault_holds: assert property (@(posedge mclk) disable iff (sys_rst)
    internal_fault_out |=> internal_fault_out)
    else $error("internal fault dropped before reset");
  a_fault_rises: assert property (@(posedge mclk) disable iff (sys_rst)
    core_internal_fault |=> internal_fault_out)
    else $error("internal fault not raised");
  a_shutdown_once: assert property (@(posedge mclk) disable iff (sys_rst)
    shutdown_req |=> !shutdown_req && internal_fault_out)
    else $error("shutdown pulse wrong");
  a_shutdown_first: assert property (@(posedge mclk) disable iff (sys_rst)
    fault_seen_reg |=> !shutdown_req)
    else $error("second shutdown request");
  a_ignore_holds: assert property (@(posedge mclk) disable iff (sys_rst)
    fp_op_issue && ign_sync_reg[1] && !ctrl_reg[CTRL_NE_BIT] |=> !fp_exception)
    else $error("exception while ignoring");
  a_fp_raise: assert property (@(posedge mclk) disable iff (sys_rst)
    fp_op_issue && fp_pending && (!ign_sync_reg[1] || ctrl_reg[CTRL_NE_BIT])
    |=> fp_exception)
    else $error("missing numeric exception");
  a_fp_clears: assert property (@(posedge mclk) disable iff (sys_rst)
    fp_exception |-> !fp_pending)
    else $error("numeric fault still pending after exception");
  a_init_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    !init_sync_reg[1] |=> int_regs_clear)
    else $error("soft init did not clear");
  a_resume_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
    resume_at_reset_vector |=> !resume_at_reset_vector)
    else $error("resume request longer than one cycle");
  a_snoop_served: assert property (@(posedge mclk) disable iff (sys_rst)
    snoop_req |=> snoop_ack)
    else $error("snoop not served");
  a_lint_route: assert property (@(posedge mclk) disable iff (sys_rst)
    !ctrl_reg[CTRL_LIC_BIT] && $stable(ctrl_reg) |=>
    maskable_irq_request == $past(lint_s2_reg[0]))
    else $error("maskable route wrong");
  a_nmi_route: assert property (@(posedge mclk) disable iff (sys_rst)
    !ctrl_reg[CTRL_LIC_BIT] |=> nmi_request == $past(lint_s2_reg[1]))
    else $error("nonmaskable route wrong");
  a_lint_enabled: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_reg[CTRL_LIC_BIT] |=> !maskable_irq_request && !nmi_request)
    else $error("fallback interrupt while controller enabled");
  a_lock_span: assert property (@(posedge mclk) disable iff (sys_rst)
    lock_seq_start |=> lock_out until lock_seq_end)
    else $error("lock dropped early");
  a_lock_release: assert property (@(posedge mclk) disable iff (sys_rst)
    lock_reg == CEILS_LK_WAIT |=> !lock_out)
    else $error("lock not released");
  a_lock_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    lock_reg == CEILS_LK_IDLE && !lock_seq_start |=> !lock_out)
    else $error("lock raised without a locked sequence");
  a_mc_disable: assert property (@(posedge mclk) disable iff (sys_rst)
    !mccfg_reg[MC_EN_BIT] |=> !machine_check_fault_oe)
    else $error("machine check while disabled");
  a_mc_with_fault: assert property (@(posedge mclk) disable iff (sys_rst)
    mccfg_reg[MC_EN_BIT] && mccfg_reg[MC_INTERNAL_FAULT_OUT_BIT] && core_internal_fault
    |=> machine_check_fault_oe && internal_fault_out)
    else $error("machine check missing with internal fault");
  a_mc_observer: assert property (@(posedge mclk) disable iff (sys_rst)
    mccfg_reg[MC_EN_BIT] && mccfg_reg[MC_OBS_BIT] && bus_obs_error |=> machine_check_fault_oe)
    else $error("machine check missing for observed error");
  a_reset_quiet: assert property (@(posedge mclk)
    sys_rst |-> !lock_oe && !machine_check_fault_oe && !internal_fault_out)
    else $error("outputs driven in reset");

  c_fault: cover property (@(posedge mclk) disable iff (sys_rst) shutdown_req);
  c_lock: cover property (@(posedge mclk) disable iff (sys_rst)
    lock_seq_start ##[1:20] lock_seq_end);
  c_fpexc: cover property (@(posedge mclk) disable iff (sys_rst) fp_exception);
  c_irq: cover property (@(posedge mclk) disable iff (sys_rst) irq);
  c_init: cover property (@(posedge mclk) disable iff (sys_rst) resume_at_reset_vector);

endmodule

// ---- shared/ceils_pkg.sv ----
package ceils_pkg;

  // Machine-check option bit positions
  localparam int MC_EN_BIT   = 0;
  localparam int MC_INTERNAL_FAULT_OUT_BIT = 1;
  localparam int MC_REQ_BIT  = 2;
  localparam int MC_OBS_BIT  = 3;

  // Register offsets
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_MCCFG  = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_MASK   = 4'h3;
  localparam logic [3:0] ADDR_STATE  = 4'h4;

  // Control field positions
  localparam int CTRL_LIC_BIT = 0;
  localparam int CTRL_NE_BIT  = 1;

  // Status field positions
  localparam int ST_INTERNAL_FAULT_OUT_BIT = 0;
  localparam int ST_INIT_BIT = 1;
  localparam int ST_MC_BIT   = 2;
  localparam int ST_W        = 3;

  // Reset values
  localparam logic [1:0]      CTRL_RST  = 2'h1;
  localparam logic [3:0]      MCCFG_RST = 4'h0;
  localparam logic [ST_W-1:0] MASK_RST  = 3'h0;

  // Reset outputs fall within two clocks; reset clears them asynchronously, through no flop stage
  localparam int RESET_DROP_CYCLES = 2;

  typedef enum logic [1:0] {
    CEILS_LK_IDLE,
    CEILS_LK_HOLD,
    CEILS_LK_WAIT
  } ceils_lock_t;

endpackage
